// [logic/bzt_pkg.sv]
// Constants, register map and types of the buzzer tone session generator.
// Assumes a 32-bit AXI4-Lite register bus and one 200 MHz system clock.
package bzt_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [29:0] IDX_TONE_FREQ_LOW = 30'h0000A128;
  localparam logic [29:0] IDX_FRAME_PULSE = 30'h0000A129;
  localparam logic [29:0] IDX_SESSION_FRAMES = 30'h0000A12A;
  localparam logic [29:0] IDX_TONE_CONFIG = 30'h0000A12B;
  localparam logic [29:0] IDX_SESSION_MUTE = 30'h0000A12C;
  localparam logic [29:0] IDX_IRQ_STATUS = 30'h0000A12D;
  localparam logic [29:0] IDX_IRQ_MASK = 30'h0000A12E;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_TONE_FREQ_LOW = 8'h10;
  localparam logic [7:0] RST_FRAME_PULSE = 8'hF0;
  localparam logic [7:0] RST_SESSION_FRAMES = 8'h80;
  localparam logic [7:0] RST_SESSION_MUTE = 8'hFF;
  localparam logic RST_IRQ_MASK = 1'h0;

  // ----------------------------------------------------------------
  // Configuration bit positions and field layout
  // ----------------------------------------------------------------
  localparam int CFG_ENABLE = 7;
  localparam int CFG_IRQ_EN = 6;
  localparam int CFG_CLK_SEL = 5;
  localparam int CFG_FREQ_MSB = 4;
  localparam int CFG_INVERT = 3;
  localparam int CFG_CONTINUOUS_MODE = 2;
  localparam int CFG_FLAG = 1;
  localparam int CFG_START = 0;
  localparam int FRAME_SOUND_LSB = 4;
  localparam int STATUS_SESSION_END = 0;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Software-written configuration carried as one bundle
  typedef struct packed {
    logic tone_enable;
    logic session_end_irq_enable;
    logic tone_clock_select;
    logic freq_msb;
    logic output_invert;
    logic continuous_mode;
  } bzt_cfg_t;

  localparam bzt_cfg_t RST_CFG = '0;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SOUND = 3'h2,
    ST_SILENT = 3'h4
  } bzt_state_t;

endpackage

// [logic/bzt_tone_gen.sv]
// Buzzer tone session generator: AXI4-Lite registers, tone divider,
// frame and session sequencer, session-end interrupt.
// Assumes tone clock sources arrive as asynchronous levels far slower
// than the 200 MHz system clock, and a synchronous active-low reset.
`timescale 1ns/10ps

module bzt_tone_gen (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic rtc_clk_i,
  input wire logic internal_fast_oscillator_i,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic tone_output_pin_o,
  output logic irq_o
);
  import bzt_pkg::*;

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [7:0] tone_divider_value;
  logic [7:0] frame_pulse_counts;
  logic [7:0] session_frame_count;
  logic [7:0] session_mute_frame;
  bzt_cfg_t cfg;
  logic session_end_flag;
  logic session_start_cmd;
  logic irq_mask;
  logic [29:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  bzt_state_t state;
  logic [8:0] div_cnt;
  logic phase;
  logic [3:0] pulse_cnt;
  logic [7:0] frame_num;
  logic [1:0] clk_s1;
  logic [1:0] clk_s2;
  logic [1:0] clk_s3;

  // Write happens once both address and data are held
  logic wr_go;
  logic wr_hit;
  logic [3:0] sound_len;
  logic [3:0] silent_len;
  logic tick;
  logic half_end;
  logic pulse_end;
  logic part_end;
  logic session_end;
  logic launch;
  logic muted;

  assign wr_go = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
  assign sound_len = frame_pulse_counts[FRAME_SOUND_LSB +: 4];
  assign silent_len = frame_pulse_counts[FRAME_SOUND_LSB-1:0];

  // ----------------------------------------------------------------
  // Tone clock synchronisers
  // ----------------------------------------------------------------
  // Index 0 is the real-time clock, index 1 the fast oscillator
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      {clk_s1, clk_s2, clk_s3} <= '0;
    end else begin
      clk_s1 <= {internal_fast_oscillator_i, rtc_clk_i};
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
    end
  end

  // Rising edge of the selected source is one tone clock tick
  assign tick = cfg.tone_clock_select ? (clk_s2[1] && !clk_s3[1])
                                      : (clk_s2[0] && !clk_s3[0]);

  // Half period ends after divider+1 ticks; a pulse is two halves
  assign half_end = tick && (div_cnt == {cfg.freq_msb, tone_divider_value});
  assign pulse_end = half_end && phase;
  assign part_end = pulse_end &&
                    (pulse_cnt == ((state == ST_SOUND) ? sound_len : silent_len) - 4'h1);
  assign launch = (state == ST_IDLE) && cfg.tone_enable &&
                  (cfg.continuous_mode || session_start_cmd);

  // Session ends with the last frame; a count of zero wraps to 256
  always_comb begin
    session_end = 1'b0;
    if (frame_num == session_frame_count) begin
      if (state == ST_SILENT) begin
        session_end = part_end;
      end else if (state == ST_SOUND && silent_len == 4'h0) begin
        session_end = part_end;
      end
    end
  end

  assign muted = frame_num > session_mute_frame;

  // ----------------------------------------------------------------
  // Frame and session sequencer
  // ----------------------------------------------------------------
  // Disable forces idle at once, whatever the phase
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !cfg.tone_enable) begin
      state <= ST_IDLE;
      div_cnt <= '0;
      phase <= 1'b0;
      pulse_cnt <= '0;
      frame_num <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          div_cnt <= '0;
          phase <= 1'b0;
          pulse_cnt <= '0;
          if (launch) begin
            frame_num <= 8'h01;
            state <= (sound_len != 4'h0) ? ST_SOUND : ST_SILENT;
          end
        end
        ST_SOUND, ST_SILENT: begin
          if (half_end) begin
            div_cnt <= '0;
            phase <= !phase;
          end else if (tick) begin
            div_cnt <= div_cnt + 9'h001;
          end
          if (pulse_end) begin
            pulse_cnt <= part_end ? 4'h0 : pulse_cnt + 4'h1;
          end
          if (session_end) begin
            frame_num <= 8'h01;
            // Continuous mode rolls straight into the next session
            if (cfg.continuous_mode) begin
              state <= (sound_len != 4'h0) ? ST_SOUND : ST_SILENT;
            end else begin
              state <= ST_IDLE;
            end
          end else if (part_end) begin
            if (state == ST_SOUND && silent_len != 4'h0) begin
              state <= ST_SILENT;
            end else begin
              frame_num <= frame_num + 8'h01;
              state <= (sound_len != 4'h0) ? ST_SOUND : ST_SILENT;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Tone output pin
  // ----------------------------------------------------------------
  // Silent, muted and idle all rest low, then polarity applies
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tone_output_pin_o <= 1'b0;
    end else begin
      tone_output_pin_o <= ((state == ST_SOUND) && !muted && phase)
                           ^ cfg.output_invert;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------
  // Ready drops after a handshake and returns once the response is accepted
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
      aw_idx <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        s_axi_awready_o <= 1'b0;
        aw_idx <= s_axi_awaddr_i[31:2];
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        s_axi_wready_o <= 1'b0;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // Held write decode; the indices are contiguous, so a range test covers them
  assign wr_hit = (aw_idx >= IDX_TONE_FREQ_LOW) && (aw_idx <= IDX_IRQ_MASK);

  // ----------------------------------------------------------------
  // Plain software registers
  // ----------------------------------------------------------------
  // Only byte lane 0 carries data; other lanes are ignored
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tone_divider_value <= RST_TONE_FREQ_LOW;
      frame_pulse_counts <= RST_FRAME_PULSE;
      session_frame_count <= RST_SESSION_FRAMES;
      session_mute_frame <= RST_SESSION_MUTE;
      cfg <= RST_CFG;
      irq_mask <= RST_IRQ_MASK;
    end else if (wr_go && w_strb[0]) begin
      if (aw_idx == IDX_TONE_FREQ_LOW) begin
        tone_divider_value <= w_data[7:0];
      end else if (aw_idx == IDX_FRAME_PULSE) begin
        frame_pulse_counts <= w_data[7:0];
      end else if (aw_idx == IDX_SESSION_FRAMES) begin
        session_frame_count <= w_data[7:0];
      end else if (aw_idx == IDX_TONE_CONFIG) begin
        cfg <= w_data[CFG_ENABLE:CFG_CONTINUOUS_MODE];
      end else if (aw_idx == IDX_SESSION_MUTE) begin
        session_mute_frame <= w_data[7:0];
      end else if (aw_idx == IDX_IRQ_MASK) begin
        irq_mask <= w_data[STATUS_SESSION_END];
      end
    end
  end

  // ----------------------------------------------------------------
  // Start command and session-end flag
  // ----------------------------------------------------------------
  // Hardware set beats a software clear in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      session_start_cmd <= 1'b0;
      session_end_flag <= 1'b0;
    end else begin
      // Start written together with enable must not be lost to the old enable
      if (wr_go && w_strb[0] && aw_idx == IDX_TONE_CONFIG &&
          w_data[CFG_START] && w_data[CFG_ENABLE]) begin
        session_start_cmd <= 1'b1;
      end else if (!cfg.tone_enable || (session_end && !cfg.continuous_mode)) begin
        session_start_cmd <= 1'b0;
      end
      if (session_end && cfg.session_end_irq_enable) begin
        session_end_flag <= 1'b1;
      end else if (wr_go && w_strb[0] &&
                   ((aw_idx == IDX_IRQ_STATUS && w_data[STATUS_SESSION_END]) ||
                    (aw_idx == IDX_TONE_CONFIG && w_data[CFG_FLAG]))) begin
        session_end_flag <= 1'b0;
      end
    end
  end

  // Level interrupt while the unmasked flag stands
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= session_end_flag && irq_mask;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channels
  // ----------------------------------------------------------------
  // One read at a time; data is captured at the address handshake
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= RESP_OKAY;
      s_axi_rdata_o <= '0;
      if (s_axi_araddr_i[31:2] == IDX_TONE_FREQ_LOW) begin
        s_axi_rdata_o[7:0] <= tone_divider_value;
      end else if (s_axi_araddr_i[31:2] == IDX_FRAME_PULSE) begin
        s_axi_rdata_o[7:0] <= frame_pulse_counts;
      end else if (s_axi_araddr_i[31:2] == IDX_SESSION_FRAMES) begin
        s_axi_rdata_o[7:0] <= session_frame_count;
      end else if (s_axi_araddr_i[31:2] == IDX_TONE_CONFIG) begin
        s_axi_rdata_o[7:0] <= {cfg, session_end_flag, (state != ST_IDLE)};
      end else if (s_axi_araddr_i[31:2] == IDX_SESSION_MUTE) begin
        s_axi_rdata_o[7:0] <= session_mute_frame;
      end else if (s_axi_araddr_i[31:2] == IDX_IRQ_STATUS) begin
        s_axi_rdata_o[STATUS_SESSION_END] <= session_end_flag;
      end else if (s_axi_araddr_i[31:2] == IDX_IRQ_MASK) begin
        s_axi_rdata_o[STATUS_SESSION_END] <= irq_mask;
      end else begin
        s_axi_rresp_o <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

endmodule

// [sim/bzt_buzzer_model.sv]
// Buzzer model: counts tone pulses and the longest high run.
// Assumes the pin is sampled on the system clock.
`timescale 1ns/10ps
module bzt_buzzer_model (
  input wire logic clk_sys_i,
  input wire logic clr_i,
  input wire logic tone_i,
  output int rises_o,
  output int max_high_o
);
  logic prev = 1'b0;
  int run = 0;
  // Edge count and high width; clear starts a new measurement
  always @(posedge clk_sys_i) begin
    prev <= tone_i;
    if (clr_i) begin
      rises_o <= 0;
      max_high_o <= 0;
      run <= 0;
    end else begin
      if (tone_i && !prev) rises_o <= rises_o + 1;
      run <= tone_i ? run + 1 : 0;
      if (tone_i && run + 1 > max_high_o) max_high_o <= run + 1;
    end
  end
endmodule

// [sim/bzt_tone_gen_props.sv]
// Checker: bus answers, tone pin idle level and interrupt relations.
// Assumes it is bound to bzt_tone_gen and sees only its ports.
`timescale 1ns/10ps
module bzt_tone_gen_props
  import bzt_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic tone_output_pin_o,
  input wire logic irq_o
);
  logic [31:0] wa;
  logic [7:0] wd;
  logic ws, bv_q, en_q, inv_q, ien_q, msk_q, clr_q, ar_hit;
  // Shadow of written control bits, one cycle behind the design
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      {bv_q, en_q, inv_q, ien_q, msk_q, clr_q} <= 6'h00;
    end else begin
      bv_q <= s_axi_bvalid_o;
      clr_q <= 1'b0;
      if (s_axi_awvalid_i && s_axi_awready_o) wa <= s_axi_awaddr_i;
      if (s_axi_wvalid_i && s_axi_wready_o) wd <= s_axi_wdata_i[7:0];
      if (s_axi_wvalid_i && s_axi_wready_o) ws <= s_axi_wstrb_i[0];
      if (s_axi_bvalid_o && !bv_q && ws && wa[31:2] == IDX_TONE_CONFIG) begin
        en_q <= wd[CFG_ENABLE];
        inv_q <= wd[CFG_INVERT];
        ien_q <= wd[CFG_IRQ_EN];
        clr_q <= wd[CFG_FLAG];
      end
      if (s_axi_bvalid_o && !bv_q && ws && wa[31:2] == IDX_IRQ_MASK) msk_q <= wd[0];
      if (s_axi_bvalid_o && !bv_q && ws && wa[31:2] == IDX_IRQ_STATUS) clr_q <= wd[0];
    end
  end
  assign ar_hit = s_axi_araddr_i[1:0] == 2'h0 && s_axi_araddr_i[31:2] >= IDX_TONE_FREQ_LOW
                  && s_axi_araddr_i[31:2] <= IDX_IRQ_MASK;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_ar_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  property p_rst;
    @(posedge clk_sys_i) disable iff (1'b0)
    !rst_n_i |=> !tone_output_pin_o && !irq_o && !s_axi_bvalid_o && !s_axi_rvalid_o;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_unmapped;
    s_ar_take ##0 !ar_hit |=> s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_mapped;
    s_ar_take ##0 ar_hit |=> s_axi_rvalid_o && s_axi_rresp_o == RESP_OKAY
      && s_axi_rdata_o[31:8] == 24'h0;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped read answer wrong");
  property p_bhold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped early");
  property p_busy;
    s_ar_take ##0 (s_axi_araddr_i[31:2] == IDX_TONE_CONFIG && tone_output_pin_o != inv_q)
      |=> s_axi_rdata_o[CFG_START];
  endproperty
  a_busy: assert property (p_busy) else $error("busy low while tone sounds");
  property p_quiet;
    !en_q [*2] |-> tone_output_pin_o == inv_q;
  endproperty
  a_quiet: assert property (p_quiet) else $error("tone pin active while disabled");
  property p_mask;
    !msk_q [*2] |-> !irq_o;
  endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt asserted");
  property p_irq_en;
    $rose(irq_o) |-> ien_q;
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("interrupt with enable off");
  property p_clr;
    clr_q |-> ##[0:2] !irq_o;
  endproperty
  a_clr: assert property (p_clr) else $error("flag clear did not drop irq");
endmodule

bind bzt_tone_gen bzt_tone_gen_props bzt_tone_gen_props_i (.*);

// [sim/tb_top.sv]
// Testbench: registers over AXI4-Lite, sessions compared with a model.
// Assumes bzt_pkg, bzt_tone_gen and the buzzer model compile first.
`timescale 1ns/10ps
module tb_top;
  import bzt_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] tdiv = 8'h00;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, lfsr = 32'h00010DCE;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic clr = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin, irq;
  logic [1:0] bresp, rresp;
  logic [7:0] rv[$] = '{8'h10, 8'hF0, 8'h80, 8'h00, 8'hFF, 8'h00, 8'h00};
  int rises, max_high, fails = 0, n_tests = 0, cyc = 0;
  // Tone sources: fast one every 8 cycles, slow one every 32
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) tdiv <= tdiv + 8'h01;
  bzt_tone_gen bzt_tone_gen_i (
    .clk_sys_i(clk_sys), .rst_n_i(rst_n), .rtc_clk_i(tdiv[4]),
    .internal_fast_oscillator_i(tdiv[2]), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .tone_output_pin_o(pin), .irq_o(irq)
  );
  bzt_buzzer_model bzt_buzzer_model_i (
    .clk_sys_i(clk_sys), .clr_i(clr), .tone_i(pin), .rises_o(rises), .max_high_o(max_high)
  );
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [29:0] i, input logic [7:0] d, input logic [1:0] er);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    @(posedge clk_sys);
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(a && w)) begin
      @(posedge clk_sys);
      if (!a && awready === 1'b1) begin
        a = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [29:0] i, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    araddr <= {i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rdc(input logic [29:0] i, input logic [7:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(i, d, r);
    chk(d, {24'h0, e});
    chk({30'h0, r}, {30'h0, er});
  endtask
  // One software-started session; expectations from the programmed fields
  task automatic run(input logic [7:0] f, fm, nf, mu, cfg, input int per);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = {cfg[CFG_FREQ_MSB], f} + 1;
    wr(IDX_TONE_FREQ_LOW, f, RESP_OKAY);
    wr(IDX_FRAME_PULSE, fm, RESP_OKAY);
    wr(IDX_SESSION_FRAMES, nf, RESP_OKAY);
    wr(IDX_SESSION_MUTE, mu, RESP_OKAY);
    wr(IDX_TONE_CONFIG, cfg & 8'hFE, RESP_OKAY);
    @(posedge clk_sys);
    chk({31'h0, pin}, {31'h0, cfg[CFG_INVERT]});
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    wr(IDX_TONE_CONFIG, cfg, RESP_OKAY);
    do rd(IDX_TONE_CONFIG, d, r); while (d[CFG_START] === 1'b1);
    chk(rises, fm[7:4] * ((nf < mu) ? nf : mu));
    if (!cfg[CFG_INVERT]) chk(max_high, n * per);
    chk(d, {24'h0, cfg[7:2], cfg[CFG_IRQ_EN], 1'b0});
    chk({31'h0, irq}, {31'h0, cfg[CFG_IRQ_EN]});
    wr(IDX_IRQ_STATUS, 8'h01, RESP_OKAY);
    rdc(IDX_IRQ_STATUS, 8'h00, RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    $display("session test done, config %h", cfg);
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      end_of_test();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) rdc(IDX_TONE_FREQ_LOW + 30'(i), rv[i], RESP_OKAY);
    rdc(30'h0000A12F, 8'h00, RESP_SLVERR);
    wr(30'h0000A12F, 8'h5A, RESP_SLVERR);
    lfsr = nxt(lfsr);
    wr(IDX_SESSION_MUTE, lfsr[7:0], RESP_OKAY);
    rdc(IDX_SESSION_MUTE, lfsr[7:0], RESP_OKAY);
    wr(IDX_IRQ_MASK, 8'h01, RESP_OKAY);
    $display("register test done");
    // Sounding plus silent counts kept above one in every row
    run(8'h01, 8'h31, 8'h02, 8'hFF, 8'hE1, 8);
    run(8'h00, 8'h21, 8'h03, 8'h01, 8'hA9, 8);
    run(8'h00, 8'h21, 8'h01, 8'hFF, 8'hF1, 8);
    lfsr = nxt(lfsr);
    run({6'h00, lfsr[1:0]}, 8'h21, 8'h01, 8'hFF, 8'hC1, 32);
    wr(IDX_TONE_FREQ_LOW, 8'h00, RESP_OKAY);
    wr(IDX_SESSION_FRAMES, 8'h01, RESP_OKAY);
    wr(IDX_TONE_CONFIG, 8'hE4, RESP_OKAY);
    @(posedge clk_sys);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    repeat (200) @(posedge clk_sys);
    chk({31'h0, rises >= 6}, 32'h1);
    rdc(IDX_TONE_CONFIG, 8'hE7, RESP_OKAY);
    wr(IDX_TONE_CONFIG, 8'h00, RESP_OKAY);
    rdc(IDX_TONE_CONFIG, 8'h02, RESP_OKAY);
    chk({31'h0, pin}, 32'h0);
    wr(IDX_TONE_CONFIG, 8'h02, RESP_OKAY);
    rdc(IDX_TONE_CONFIG, 8'h00, RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    // Enable and start in one write from the disabled state
    wr(IDX_TONE_CONFIG, 8'hE1, RESP_OKAY);
    repeat (100) @(posedge clk_sys);
    rdc(IDX_TONE_CONFIG, 8'hE2, RESP_OKAY);
    wr(IDX_IRQ_STATUS, 8'h01, RESP_OKAY);
    $display("continuous test done");
    end_of_test();
  end
endmodule
